//--- src/irq_ctrl_pkg.sv
// constants and types for the interrupt controller
package irq_ctrl_pkg;
   localparam int NUM_SRC = 11;
   localparam int NUM_LVL = 4;
   localparam logic [7:0] ADDR_EN_FIRST = 8'ha8;
   localparam logic [7:0] ADDR_EN_SECOND = 8'he8;
   localparam logic [7:0] ADDR_PRIO_LOW0 = 8'hb8;
   localparam logic [7:0] ADDR_PRIO_HIGH0 = 8'hb7;
   localparam logic [7:0] ADDR_PRIO_LOW1 = 8'hf8;
   localparam logic [7:0] ADDR_PRIO_HIGH1 = 8'hf7;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam int BIT_MASTER = 7;
   localparam int BIT_PCA = 6;
   localparam int BIT_T2 = 5;
   localparam int BIT_UART = 4;
   localparam int BIT_T1 = 3;
   localparam int BIT_PIN1 = 2;
   localparam int BIT_T0 = 1;
   localparam int BIT_PIN0 = 0;
   localparam int BIT_SPI = 3;
   localparam int BIT_CANTIM = 2;
   localparam int BIT_ADC = 1;
   localparam int BIT_CAN = 0;
   localparam logic [3:0] SECOND_MASK = 4'hf;
   localparam logic [6:0] FIRST_MASK = 7'h7f;
   // source index = polling rank, 0 polled first
   localparam int SRC_PIN0 = 0;
   localparam int SRC_T0 = 1;
   localparam int SRC_PIN1 = 2;
   localparam int SRC_T1 = 3;
   localparam int SRC_PCA = 4;
   localparam int SRC_UART = 5;
   localparam int SRC_T2 = 6;
   localparam int SRC_CAN = 7;
   localparam int SRC_ADC = 8;
   localparam int SRC_CANTIM = 9;
   localparam int SRC_SPI = 10;
   typedef logic [15:0] vector_t;
   localparam vector_t VEC_TABLE [NUM_SRC] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0033,
      16'h0023, 16'h002b, 16'h003b, 16'h0043, 16'h004b, 16'h0053};
   typedef enum logic [1:0] {IDLE, OFFER} arb_state_t;
endpackage : irq_ctrl_pkg

//--- src/irq_ctrl.sv
// interrupt controller: enables, four-level priority, polling order, vector hand-off
`timescale 1ns/100ps
module irq_ctrl (
   input wire logic CLOCK,
   input wire logic RESETN,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WRITE,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_READ,
   input wire logic BIT_WRITE,
   input wire logic [2:0] BIT_SEL,
   input wire logic BIT_VALUE,
   output logic [7:0] REG_RDATA,
   input wire logic OUTSIDE_IRQ_PIN0,
   input wire logic TIMER0_OVERFLOW_FLAG,
   input wire logic OUTSIDE_IRQ_PIN1,
   input wire logic TIMER1_OVERFLOW_FLAG,
   input wire logic PCA_COUNTER_OVERFLOW_FLAG,
   input wire logic PCA_MODULE_MATCH_FLAG,
   input wire logic UART_RECEIVE_DONE,
   input wire logic UART_TRANSMIT_DONE,
   input wire logic TIMER2_OVERFLOW_FLAG,
   input wire logic CAN_EVENT,
   input wire logic CAN_BUFFER_OVERRUN,
   input wire logic ADC_DONE_FLAG,
   input wire logic CAN_TIMER_WRAP_FLAG,
   input wire logic SPI_EVENT,
   output logic IRQ_REQ,
   output logic [15:0] IRQ_VECTOR,
   output logic [3:0] IRQ_SRC,
   input wire logic IRQ_ACK,
   input wire logic IRQ_RETURN,
   output logic [1:0] ACTIVE_LEVEL,
   output logic ACTIVE_ANY
);
   localparam int N = irq_ctrl_pkg::NUM_SRC;
   localparam int L = irq_ctrl_pkg::NUM_LVL;
   // the source wiring and the level stack below are written out for this exact shape,
   // so any other count in the package is refused rather than silently mis-wired
   initial begin
      if (N != 11 || L != 4) $error("irq_ctrl supports exactly 11 sources and 4 levels");
      // first enable register bit positions must fall inside the byte
      if (irq_ctrl_pkg::BIT_MASTER > 7) $error("master enable bit out of range");
      if (irq_ctrl_pkg::BIT_PCA > 7) $error("counter array enable bit out of range");
      if (irq_ctrl_pkg::BIT_T2 > 7) $error("timer 2 enable bit out of range");
      if (irq_ctrl_pkg::BIT_UART > 7) $error("uart enable bit out of range");
      if (irq_ctrl_pkg::BIT_T1 > 7) $error("timer 1 enable bit out of range");
      if (irq_ctrl_pkg::BIT_PIN1 > 7) $error("pin 1 enable bit out of range");
      if (irq_ctrl_pkg::BIT_T0 > 7) $error("timer 0 enable bit out of range");
      if (irq_ctrl_pkg::BIT_PIN0 > 7) $error("pin 0 enable bit out of range");
      // the second enable register only keeps its low nibble
      if (irq_ctrl_pkg::BIT_SPI > 3) $error("spi enable bit out of range");
      if (irq_ctrl_pkg::BIT_CANTIM > 3) $error("can timer enable bit out of range");
      if (irq_ctrl_pkg::BIT_ADC > 3) $error("adc enable bit out of range");
      if (irq_ctrl_pkg::BIT_CAN > 3) $error("can enable bit out of range");
      // raw_req and src_en are packed in rank order; the indices must agree with it
      if (irq_ctrl_pkg::SRC_PIN0 != 0) $error("pin 0 rank mismatch");
      if (irq_ctrl_pkg::SRC_T0 != 1) $error("timer 0 rank mismatch");
      if (irq_ctrl_pkg::SRC_PIN1 != 2) $error("pin 1 rank mismatch");
      if (irq_ctrl_pkg::SRC_T1 != 3) $error("timer 1 rank mismatch");
      if (irq_ctrl_pkg::SRC_PCA != 4) $error("counter array rank mismatch");
      if (irq_ctrl_pkg::SRC_UART != 5) $error("uart rank mismatch");
      if (irq_ctrl_pkg::SRC_T2 != 6) $error("timer 2 rank mismatch");
      if (irq_ctrl_pkg::SRC_CAN != 7) $error("can rank mismatch");
      if (irq_ctrl_pkg::SRC_ADC != 8) $error("adc rank mismatch");
      if (irq_ctrl_pkg::SRC_CANTIM != 9) $error("can timer rank mismatch");
      if (irq_ctrl_pkg::SRC_SPI != 10) $error("spi rank mismatch");
      // every vector sits three bytes into an eight-byte slot
      for (int i = 0; i < N; i++) begin
         if (irq_ctrl_pkg::VEC_TABLE[i][2:0] != 3'h3) $error("vector table entry misaligned");
      end
   end

   logic [7:0] en_first_q, en_first_d;
   logic [3:0] en_second_q, en_second_d;
   logic [7:0] prio_low0_q, prio_low0_d, prio_high0_q, prio_high0_d;
   logic [3:0] prio_low1_q, prio_low1_d, prio_high1_q, prio_high1_d;
   logic [7:0] rdata_q, rdata_d;

   // register writes; a bit access touches only the selected bit of the first enable register
   always_comb begin
      en_first_d = en_first_q;
      en_second_d = en_second_q;
      prio_low0_d = prio_low0_q;
      prio_high0_d = prio_high0_q;
      prio_low1_d = prio_low1_q;
      prio_high1_d = prio_high1_q;
      if (REG_WRITE) begin
         case (REG_ADDR)
            irq_ctrl_pkg::ADDR_EN_FIRST: en_first_d = REG_WDATA;
            irq_ctrl_pkg::ADDR_EN_SECOND: en_second_d = REG_WDATA[3:0] & irq_ctrl_pkg::SECOND_MASK;
            irq_ctrl_pkg::ADDR_PRIO_LOW0: prio_low0_d = {1'b0, REG_WDATA[6:0] & irq_ctrl_pkg::FIRST_MASK};
            irq_ctrl_pkg::ADDR_PRIO_HIGH0: prio_high0_d = {1'b0, REG_WDATA[6:0] & irq_ctrl_pkg::FIRST_MASK};
            irq_ctrl_pkg::ADDR_PRIO_LOW1: prio_low1_d = REG_WDATA[3:0];
            irq_ctrl_pkg::ADDR_PRIO_HIGH1: prio_high1_d = REG_WDATA[3:0];
            default: ;
         endcase
      end else if (BIT_WRITE) begin
         en_first_d[BIT_SEL] = BIT_VALUE;
      end
      rdata_d = rdata_q;
      if (REG_READ) begin
         case (REG_ADDR)
            irq_ctrl_pkg::ADDR_EN_FIRST: rdata_d = en_first_q;
            irq_ctrl_pkg::ADDR_EN_SECOND: rdata_d = {4'h0, en_second_q};
            irq_ctrl_pkg::ADDR_PRIO_LOW0: rdata_d = prio_low0_q;
            irq_ctrl_pkg::ADDR_PRIO_HIGH0: rdata_d = prio_high0_q;
            irq_ctrl_pkg::ADDR_PRIO_LOW1: rdata_d = {4'h0, prio_low1_q};
            irq_ctrl_pkg::ADDR_PRIO_HIGH1: rdata_d = {4'h0, prio_high1_q};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
         en_first_q <= irq_ctrl_pkg::RESET_BYTE;
         en_second_q <= 4'h0;
         prio_low0_q <= irq_ctrl_pkg::RESET_BYTE;
         prio_high0_q <= irq_ctrl_pkg::RESET_BYTE;
         prio_low1_q <= 4'h0;
         prio_high1_q <= 4'h0;
         rdata_q <= irq_ctrl_pkg::RESET_BYTE;
      end else begin
         en_first_q <= en_first_d;
         en_second_q <= en_second_d;
         prio_low0_q <= prio_low0_d;
         prio_high0_q <= prio_high0_d;
         prio_low1_q <= prio_low1_d;
         prio_high1_q <= prio_high1_d;
         rdata_q <= rdata_d;
      end
   end
   assign REG_RDATA = rdata_q;

   // per-source request, enable and level, indexed by polling rank
   logic [N-1:0] raw_req, src_en, gated;
   logic [1:0] lvl [N];
   assign raw_req = {SPI_EVENT, CAN_TIMER_WRAP_FLAG, ADC_DONE_FLAG, CAN_EVENT | CAN_BUFFER_OVERRUN,
      TIMER2_OVERFLOW_FLAG, UART_RECEIVE_DONE | UART_TRANSMIT_DONE,
      PCA_COUNTER_OVERFLOW_FLAG | PCA_MODULE_MATCH_FLAG, TIMER1_OVERFLOW_FLAG, OUTSIDE_IRQ_PIN1,
      TIMER0_OVERFLOW_FLAG, OUTSIDE_IRQ_PIN0};
   // enables reordered from register bit positions into polling rank
   assign src_en = {en_second_q[irq_ctrl_pkg::BIT_SPI], en_second_q[irq_ctrl_pkg::BIT_CANTIM],
      en_second_q[irq_ctrl_pkg::BIT_ADC], en_second_q[irq_ctrl_pkg::BIT_CAN],
      en_first_q[irq_ctrl_pkg::BIT_T2], en_first_q[irq_ctrl_pkg::BIT_UART],
      en_first_q[irq_ctrl_pkg::BIT_PCA], en_first_q[irq_ctrl_pkg::BIT_T1],
      en_first_q[irq_ctrl_pkg::BIT_PIN1], en_first_q[irq_ctrl_pkg::BIT_T0],
      en_first_q[irq_ctrl_pkg::BIT_PIN0]};
   // priority bits follow the same order as the enables
   logic [N-1:0] lo_r, hi_r;
   assign lo_r = {prio_low1_q[3], prio_low1_q[2], prio_low1_q[1], prio_low1_q[0],
      prio_low0_q[5], prio_low0_q[4], prio_low0_q[6], prio_low0_q[3:0]};
   assign hi_r = {prio_high1_q[3], prio_high1_q[2], prio_high1_q[1], prio_high1_q[0],
      prio_high0_q[5], prio_high0_q[4], prio_high0_q[6], prio_high0_q[3:0]};

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_src
         assign gated[g] = raw_req[g] & src_en[g] & en_first_q[irq_ctrl_pkg::BIT_MASTER];
         assign lvl[g] = {hi_r[g], lo_r[g]};
      end
   endgenerate

   // winner: highest level first, lowest rank within a level
   logic win_any;
   logic [3:0] win_idx;
   logic [1:0] win_lvl;
   always_comb begin
      win_any = 1'b0;
      win_idx = 4'h0;
      win_lvl = 2'b00;
      for (int i = 0; i < N; i++) begin
         if (gated[i] && (!win_any || lvl[i] > win_lvl)) begin
            win_any = 1'b1;
            win_idx = 4'(i);
            win_lvl = lvl[i];
         end
      end
   end

   // active-level stack: one bit per level in progress, so nesting returns correctly
   logic [L-1:0] active_q, active_d;
   logic [1:0] cur_lvl;
   logic cur_any;
   always_comb begin
      cur_any = |active_q;
      cur_lvl = 2'b00;
      for (int k = 0; k < L; k++) begin
         if (active_q[k]) cur_lvl = 2'(k);
      end
   end
   // strictly higher only; level 3 can never be exceeded so it is never preempted
   logic may_preempt;
   assign may_preempt = win_any && (!cur_any || win_lvl > cur_lvl);

   irq_ctrl_pkg::arb_state_t state_q, state_d;
   logic req_q, req_d;
   logic [15:0] vec_q, vec_d;
   logic [3:0] src_q, src_d;
   logic [1:0] offer_lvl_q, offer_lvl_d;
   logic [1:0] act_lvl_q, act_lvl_d;
   logic act_any_q, act_any_d;

   always_comb begin
      state_d = state_q;
      req_d = req_q;
      vec_d = vec_q;
      src_d = src_q;
      offer_lvl_d = offer_lvl_q;
      active_d = active_q;
      if (IRQ_RETURN && cur_any) active_d[cur_lvl] = 1'b0;
      case (state_q)
         irq_ctrl_pkg::IDLE: begin
            if (may_preempt && !IRQ_RETURN) begin
               state_d = irq_ctrl_pkg::OFFER;
               req_d = 1'b1;
               vec_d = irq_ctrl_pkg::VEC_TABLE[win_idx];
               src_d = win_idx;
               offer_lvl_d = win_lvl;
            end
         end
         irq_ctrl_pkg::OFFER: begin
            if (IRQ_ACK) begin
               state_d = irq_ctrl_pkg::IDLE;
               req_d = 1'b0;
               active_d[offer_lvl_q] = 1'b1;
            end else if (may_preempt) begin
               // keep the offer current while the core has not taken it
               vec_d = irq_ctrl_pkg::VEC_TABLE[win_idx];
               src_d = win_idx;
               offer_lvl_d = win_lvl;
            end
         end
         default: begin
            state_d = irq_ctrl_pkg::IDLE;
            req_d = 1'b0;
         end
      endcase
      act_any_d = |active_d;
      act_lvl_d = 2'b00;
      for (int k = 0; k < L; k++) begin
         if (active_d[k]) act_lvl_d = 2'(k);
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
         state_q <= irq_ctrl_pkg::IDLE;
         req_q <= 1'b0;
         vec_q <= 16'h0000;
         src_q <= 4'h0;
         offer_lvl_q <= 2'b00;
         active_q <= '0;
         act_lvl_q <= 2'b00;
         act_any_q <= 1'b0;
      end else begin
         state_q <= state_d;
         req_q <= req_d;
         vec_q <= vec_d;
         src_q <= src_d;
         offer_lvl_q <= offer_lvl_d;
         active_q <= active_d;
         act_lvl_q <= act_lvl_d;
         act_any_q <= act_any_d;
      end
   end
   assign IRQ_REQ = req_q;
   assign IRQ_VECTOR = vec_q;
   assign IRQ_SRC = src_q;
   assign ACTIVE_LEVEL = act_lvl_q;
   assign ACTIVE_ANY = act_any_q;
endmodule : irq_ctrl

//--- bench/irq_ctrl_monitor.sv
// assertion checker for the core-side handshake of the interrupt controller
`timescale 1ns/100ps
module irq_ctrl_monitor (
   input wire logic CLOCK,
   input wire logic RESETN,
   input wire logic IRQ_REQ,
   input wire logic [15:0] IRQ_VECTOR,
   input wire logic [3:0] IRQ_SRC,
   input wire logic IRQ_ACK,
   input wire logic IRQ_RETURN,
   input wire logic [1:0] ACTIVE_LEVEL,
   input wire logic ACTIVE_ANY
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RESETN);
   chk_offer_holds: assert property (IRQ_REQ && !IRQ_ACK |=> IRQ_REQ) else $error("offer withdrawn before ack");
   chk_ack_drops: assert property (IRQ_REQ && IRQ_ACK |=> !IRQ_REQ && ACTIVE_ANY) else $error("ack not taken");
   chk_vector_map: assert property (IRQ_REQ |-> IRQ_SRC < 4'hb && IRQ_VECTOR == irq_ctrl_pkg::VEC_TABLE[IRQ_SRC])
      else $error("vector does not match source");
   chk_top_blocks: assert property (ACTIVE_LEVEL == 2'h3 |-> !IRQ_REQ) else $error("offer during top level");
   chk_preempt_up: assert property (IRQ_REQ && IRQ_ACK && ACTIVE_ANY && !IRQ_RETURN |=>
      ACTIVE_LEVEL > $past(ACTIVE_LEVEL)) else $error("preemption not higher");
   chk_return_pops: assert property (ACTIVE_ANY && ACTIVE_LEVEL == 2'h0 && IRQ_RETURN && !IRQ_ACK |=> !ACTIVE_ANY)
      else $error("return did not pop");
   chk_idle_level: assert property (!ACTIVE_ANY |-> ACTIVE_LEVEL == 2'h0) else $error("level without handler");
   chk_ack_level: assert property (IRQ_REQ && IRQ_ACK && !ACTIVE_ANY |=> ACTIVE_ANY [*2] or IRQ_RETURN)
      else $error("handler not held");
endmodule : irq_ctrl_monitor
bind irq_ctrl irq_ctrl_monitor mon (.CLOCK, .RESETN, .IRQ_REQ, .IRQ_VECTOR, .IRQ_SRC, .IRQ_ACK, .IRQ_RETURN,
   .ACTIVE_LEVEL, .ACTIVE_ANY);

//--- bench/core_model.sv
// processor core stand-in: accepts an offer after a set delay and records the vector
`timescale 1ns/100ps
module core_model (
   input wire logic clock,
   input wire logic irq_req,
   input wire logic [15:0] irq_vector,
   input wire logic [3:0] ack_wait,
   output logic irq_ack,
   output logic [15:0] taken_vec,
   output int taken_n
);
   int waited = 0;
   initial begin
      irq_ack = 1'b0;
      taken_vec = 16'h0000;
      taken_n = 0;
   end
   // ack changes on the falling edge so it is steady through the sampling edge
   always @(negedge clock) begin
      irq_ack <= irq_req && !irq_ack && waited >= ack_wait;
      waited <= (irq_req && !irq_ack) ? waited + 1 : 0;
   end
   always @(posedge clock) begin
      if (irq_req && irq_ack) begin
         taken_vec <= irq_vector;
         taken_n <= taken_n + 1;
      end
   end
endmodule : core_model

//--- bench/irq_ctrl_test.sv
// self-checking bench for the interrupt controller
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module irq_ctrl_test;
   logic clock = 0, resetn = 0, reg_write = 0, reg_read = 0, bit_write = 0, bit_value = 0, irq_return = 0, alt = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, rdata;
   logic [2:0] bit_sel = 0;
   logic [10:0] s = 0;
   logic [15:0] vec, taken_vec;
   logic [3:0] srcidx, ack_wait = 0;
   logic req, ack, aany;
   logic [1:0] alvl;
   int taken_n, n_fail = 0, checks_done = 0;
   logic [15:0] ev [11] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0033, 16'h0023, 16'h002b, 16'h003b,
      16'h0043, 16'h004b, 16'h0053};
   logic [11:0] en [11] = '{12'h001, 12'h002, 12'h004, 12'h008, 12'h040, 12'h010, 12'h020, 12'h100, 12'h200,
      12'h400, 12'h800};
   irq_ctrl uut (.CLOCK(clock), .RESETN(resetn), .REG_ADDR(reg_addr), .REG_WRITE(reg_write), .REG_WDATA(reg_wdata),
      .REG_READ(reg_read), .BIT_WRITE(bit_write), .BIT_SEL(bit_sel), .BIT_VALUE(bit_value), .REG_RDATA(rdata),
      .OUTSIDE_IRQ_PIN0(s[0]), .TIMER0_OVERFLOW_FLAG(s[1]), .OUTSIDE_IRQ_PIN1(s[2]), .TIMER1_OVERFLOW_FLAG(s[3]),
      .PCA_COUNTER_OVERFLOW_FLAG(s[4] & !alt), .PCA_MODULE_MATCH_FLAG(s[4] & alt), .UART_RECEIVE_DONE(s[5] & !alt),
      .UART_TRANSMIT_DONE(s[5] & alt), .TIMER2_OVERFLOW_FLAG(s[6]), .CAN_EVENT(s[7] & !alt),
      .CAN_BUFFER_OVERRUN(s[7] & alt), .ADC_DONE_FLAG(s[8]), .CAN_TIMER_WRAP_FLAG(s[9]), .SPI_EVENT(s[10]),
      .IRQ_REQ(req), .IRQ_VECTOR(vec), .IRQ_SRC(srcidx), .IRQ_ACK(ack), .IRQ_RETURN(irq_return),
      .ACTIVE_LEVEL(alvl), .ACTIVE_ANY(aany));
   core_model core (.clock(clock), .irq_req(req), .irq_vector(vec), .ack_wait(ack_wait), .irq_ack(ack),
      .taken_vec(taken_vec), .taken_n(taken_n));
   initial begin
      forever #2.5 clock = ~clock;
   end
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge clock);
      reg_write = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clock);
      reg_addr = a;
      reg_read = 1'b1;
      @(negedge clock);
      reg_read = 1'b0;
      `CHK(rdata, e)
   endtask : rd
   task automatic bitw(input logic [2:0] b, input logic v);
      @(negedge clock);
      bit_sel = b;
      bit_value = v;
      bit_write = 1'b1;
      @(negedge clock);
      bit_write = 1'b0;
   endtask : bitw
   // waits for the core to accept an offer, then checks vector and running level
   task automatic take(input logic [15:0] e, input logic [1:0] l);
      int n0;
      n0 = taken_n;
      for (int k = 0; k < 30 && taken_n == n0; k++) @(negedge clock);
      if (taken_n == n0) begin
         n_fail++;
         report_and_stop();
      end
      `CHK(taken_vec, e)
      `CHK(alvl, l)
   endtask : take
   task automatic ret();
      @(negedge clock);
      irq_return = 1'b1;
      @(negedge clock);
      irq_return = 1'b0;
   endtask : ret
   task automatic quiet();
      repeat (4) @(negedge clock);
      `CHK(req, 1'b0)
   endtask : quiet
   initial begin
      repeat (8) @(negedge clock);
      resetn = 1'b1;
      `CHK(req, 1'b0)
      `CHK(aany, 1'b0)
      rd(8'ha8, 8'h00);
      rd(8'he8, 8'h00);
      rd(8'h55, 8'h00);
      bitw(3'h3, 1'b1);
      rd(8'ha8, 8'h08);
      wr(8'ha8, 8'h7f);
      wr(8'he8, 8'h0f);
      s = 11'h7ff;
      quiet();
      s = 0;
      bitw(3'h7, 1'b1);
      rd(8'ha8, 8'hff);
      for (int i = 0; i < 11; i++) begin
         alt = ~i[0];
         ack_wait = {2'b00, i[1:0]};
         s = 11'h7ff << i;
         take(ev[i], 2'h0);
         `CHK(srcidx, 4'(i))
         s = 0;
         ret();
      end
      for (int i = 0; i < 11; i++) begin
         alt = i[0];
         wr(8'ha8, 8'h80 | en[i][7:0]);
         wr(8'he8, {4'h0, en[i][11:8]});
         s = 11'h7ff;
         take(ev[i], 2'h0);
         s = 0;
         ret();
      end
      wr(8'ha8, 8'h81);
      for (int lv = 0; lv < 4; lv++) begin
         wr(8'hb8, {7'h0, lv[0]});
         wr(8'hb7, {7'h0, lv[1]});
         s = 11'h001;
         take(16'h0003, lv[1:0]);
         s = 0;
         ret();
      end
      wr(8'ha8, 8'hff);
      wr(8'hb8, 8'h02);
      wr(8'hb7, 8'h00);
      wr(8'hf8, 8'h08);
      wr(8'hf7, 8'h08);
      s = 11'h001;
      take(16'h0003, 2'h0);
      s = 11'h003;
      take(16'h000b, 2'h1);
      s = 11'h007;
      quiet();
      s = 11'h407;
      take(16'h0053, 2'h3);
      s = 11'h7ff;
      quiet();
      s = 0;
      repeat (3) ret();
      `CHK(aany, 1'b0)
      s = 11'h7ff;
      take(16'h0053, 2'h3);
      s = 0;
      ret();
      report_and_stop();
   end
endmodule : irq_ctrl_test
